// ---- brc_pkg.sv ----
package brc_pkg;
	// Register offsets and field layout of the routing configuration word
	localparam logic [7:0]  BRC_CFG_OFFSET   = 8'h50;
	localparam logic [15:0] BRC_CFG_RESET    = 16'h0000;
	localparam int          BRC_SGC_MSB      = 15;
	localparam int          BRC_SGC_LSB      = 13;
	localparam int          BRC_MONO_ADAPTER_PRESENT_BIT     = 5;
	localparam logic [15:0] BRC_CFG_WMASK    = 16'hE020;
	// Mono adapter memory window, byte addresses
	localparam logic [31:0] BRC_MDA_MEM_LO   = 32'h000B0000;
	localparam logic [31:0] BRC_MDA_MEM_HI   = 32'h000B7FFF;
	// Mono adapter I/O ports, low ten address bits only
	localparam logic [9:0]  BRC_MDA_P0       = 10'h3B4;
	localparam logic [9:0]  BRC_MDA_P1       = 10'h3B5;
	localparam logic [9:0]  BRC_MDA_P2       = 10'h3B8;
	localparam logic [9:0]  BRC_MDA_P3       = 10'h3B9;
	localparam logic [9:0]  BRC_MDA_P4       = 10'h3BA;
	localparam logic [9:0]  BRC_MDA_P5       = 10'h3BF;
	localparam logic [9:0]  BRC_PAR_LO       = 10'h3BC;
	localparam logic [9:0]  BRC_PAR_HI       = 10'h3BF;
	// Route targets: 0 is the primary hub link, 1..N the secondary links
	localparam logic [1:0]  BRC_TGT_PRIMARY  = 2'h0;
	localparam int          BRC_NUM_SEC      = 3;
	typedef enum logic [1:0] {
		BRC_SG_IDLE = 2'h0,
		BRC_SG_CNT  = 2'h1,
		BRC_SG_ACK  = 2'h3
	} brc_sg_e;
endpackage

// ---- brc_route.sv ----
`timescale 1ns/1ns
// Registered routing decision for one processor access
module brc_route
	import brc_pkg::*;
#(
	parameter int NSEC = BRC_NUM_SEC
) (
	input  wire logic             clk,        // Host clock
	input  wire logic             resetn,     // Async reset, low
	input  wire logic             req,        // Access valid
	input  wire logic             is_io,      // 1 I/O, 0 memory
	input  wire logic [31:0]      addr,       // Start address
	input  wire logic [2:0]       io_len,     // I/O bytes minus one
	input  wire logic             mono_adapter_present,       // Mono adapter present
	input  wire logic [NSEC-1:0]  vga_en,     // Per bridge VGA enable
	input  wire logic [NSEC-1:0]  isa_en,     // Per bridge ISA enable
	input  wire logic [NSEC-1:0]  io_win,     // Address inside window
	input  wire logic [NSEC-1:0]  vga_hit,    // Bridge VGA range hit
	output logic                  rt_valid,   // Decision valid
	output logic [1:0]            rt_target   // Chosen hub link
);
	logic [1:0] tgt_d;
	logic [1:0] tgt_q;
	logic       vld_q;

	// True when a port lies on one of the mono adapter ports
	function automatic logic mda_port(input logic [9:0] p);
		return (p == BRC_MDA_P0) || (p == BRC_MDA_P1) ||
		       (p == BRC_MDA_P2) || (p == BRC_MDA_P3) ||
		       (p == BRC_MDA_P4) || (p == BRC_MDA_P5);
	endfunction

	// Aliases fold away since only the low ten bits are compared
	logic       io_mda;
	logic       io_par;
	logic       io_mono_only;
	logic       mem_mda;
	logic       any_vga;
	logic [9:0] p;
	always_comb begin
		io_mda = 1'h0;
		io_par = 1'h0;
		io_mono_only = 1'h0;
		for (int i = 0; i < 8; i++) begin
			p = addr[9:0] + 10'(i);
			if (3'(i) <= io_len) begin
				io_mda = io_mda | mda_port(p);
				io_par = io_par |
					((p >= BRC_PAR_LO) && (p <= BRC_PAR_HI));
				io_mono_only = io_mono_only | (p == BRC_MDA_P5);
			end
		end
	end
	assign mem_mda = (addr >= BRC_MDA_MEM_LO) &&
	                 (addr <= BRC_MDA_MEM_HI);
	assign any_vga = |vga_en;

	// Priority: mono adapter rules, then VGA and parallel port range, lowest numbered bridge winning
	always_comb begin
		tgt_d = BRC_TGT_PRIMARY;
		for (int b = NSEC - 1; b >= 0; b--) begin
			if (is_io && io_par && !io_mda && !vga_en[b] && io_win[b]
			    && !isa_en[b])
				tgt_d = 2'(b + 1);
			// A VGA range hit on a VGA-enabled bridge goes to it unless mono I/O; mono override comes last
			if (vga_en[b] && vga_hit[b] && (!is_io || !io_mda))
				tgt_d = 2'(b + 1);
			if (any_vga && vga_en[b] && is_io && io_mda && !mono_adapter_present
			    && !io_mono_only)
				tgt_d = 2'(b + 1);
		end
		if (!any_vga && is_io && io_par)
			tgt_d = BRC_TGT_PRIMARY;
		if (mono_adapter_present && ((is_io && io_mda) || (!is_io && mem_mda)))
			tgt_d = BRC_TGT_PRIMARY;
	end

	// Decision registered so the outputs come from flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tgt_q <= BRC_TGT_PRIMARY;
			vld_q <= 1'h0;
		end else begin
			tgt_q <= tgt_d;
			vld_q <= req;
		end
	end
	assign rt_valid  = vld_q;
	assign rt_target = tgt_q;
endmodule

// ---- brc_top.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Count system bus stop-grants, send one acknowledge on primary link.
// - Count field value plus one gives the number of stop-grants.
// - Count field stays plain read/write, never locks.
// - Mono-present bit combines with VGA enables to steer mono accesses.
// - No VGA enable: parallel port range 3BC-3BF goes to primary link.
// - VGA clear: range goes secondary if in window and ISA clear.
// - Memory 0B0000-0B7FFF counts as mono adapter memory.
// - Mono ports decoded with upper address bits 15:10 ignored.
// - Touching any mono port makes the whole access mono.
// - VGA set, mono clear: VGA to bridge, 3BF-only to primary.
// - VGA and mono set: VGA to bridge, mono to primary.
module brc_top
	import brc_pkg::*;
#(
	parameter int NSEC = BRC_NUM_SEC
) (
	input  wire logic             clk,          // Host clock
	input  wire logic             resetn,       // Async reset, low
	input  wire logic             cfg_wr,       // Config write strobe
	input  wire logic             cfg_rd,       // Config read strobe
	input  wire logic [7:0]       cfg_addr,     // Config offset
	input  wire logic [1:0]       cfg_be,       // Byte enables
	input  wire logic [15:0]      cfg_wdata,    // Write data
	output logic [15:0]           cfg_rdata,    // Read data
	input  wire logic             sg_seen,      // Stop-grant cycle seen
	output logic                  sg_ack,       // Ack packet pulse
	input  wire logic             acc_req,      // Processor access
	input  wire logic             acc_is_io,    // I/O access
	input  wire logic [31:0]      acc_addr,     // Access address
	input  wire logic [2:0]       acc_io_len,   // I/O bytes minus one
	input  wire logic [NSEC-1:0]  vga_en,       // Bridge VGA enables
	input  wire logic [NSEC-1:0]  isa_en,       // Bridge ISA enables
	input  wire logic [NSEC-1:0]  io_win,       // Inside bridge window
	input  wire logic [NSEC-1:0]  vga_hit,      // Bridge VGA range hit
	output logic                  route_valid,  // Decision valid
	output logic [1:0]            route_target  // Chosen hub link
);
	logic [15:0] cfg_q;
	logic [15:0] cfg_d;
	logic [15:0] rdata_q;
	logic [15:0] wmask;
	logic        hit;
	logic [2:0]  sgc;
	logic [2:0]  cnt_q;
	logic [2:0]  cnt_d;
	logic        ack_q;
	logic        ack_d;
	brc_sg_e     st_q;
	brc_sg_e     st_d;

	// Byte-enabled write; reserved bits drop out through the mask
	assign hit   = (cfg_addr == BRC_CFG_OFFSET);
	assign wmask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} & BRC_CFG_WMASK;
	assign cfg_d = (cfg_wr && hit) ?
		((cfg_q & ~wmask) | (cfg_wdata & wmask)) : cfg_q;
	assign sgc   = cfg_q[BRC_SGC_MSB:BRC_SGC_LSB];

	// Count field is rewritable at any time, no write-once lock
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			cfg_q <= BRC_CFG_RESET;
		else
			cfg_q <= cfg_d;
	end

	// Unmapped offsets read zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rdata_q <= 16'h0000;
		else if (cfg_rd)
			rdata_q <= hit ? cfg_q : 16'h0000;
	end
	assign cfg_rdata = rdata_q;

	// Stop-grant counter; changing the count mid-run gives odd timing
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		ack_d = 1'h0;
		case (st_q)
			BRC_SG_IDLE, BRC_SG_CNT: begin
				if (sg_seen) begin
					if (cnt_q >= sgc) begin
						ack_d = 1'h1;
						cnt_d = 3'h0;
						st_d  = BRC_SG_ACK;
					end else begin
						cnt_d = cnt_q + 3'h1;
						st_d  = BRC_SG_CNT;
					end
				end
			end
			BRC_SG_ACK: begin
				st_d = BRC_SG_IDLE;
				if (sg_seen) begin
					cnt_d = 3'h1;
					st_d  = BRC_SG_CNT;
					if (sgc == 3'h0) begin
						ack_d = 1'h1;
						cnt_d = 3'h0;
						st_d  = BRC_SG_ACK;
					end
				end
			end
			default: begin
				st_d  = BRC_SG_IDLE;
				cnt_d = 3'h0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q  <= BRC_SG_IDLE;
			cnt_q <= 3'h0;
			ack_q <= 1'h0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			ack_q <= ack_d;
		end
	end
	assign sg_ack = ack_q;

	// Routing decision, one cycle after the access
	brc_route #(
		.NSEC (NSEC)
	) u_route (
		.clk       (clk),
		.resetn    (resetn),
		.req       (acc_req),
		.is_io     (acc_is_io),
		.addr      (acc_addr),
		.io_len    (acc_io_len),
		.mono_adapter_present      (cfg_q[BRC_MONO_ADAPTER_PRESENT_BIT]),
		.vga_en    (vga_en),
		.isa_en    (isa_en),
		.io_win    (io_win),
		.vga_hit   (vga_hit),
		.rt_valid  (route_valid),
		.rt_target (route_target)
	);
endmodule

// ---- brc_top_checker.sv ----
`timescale 1ns/1ns
// Port-level checks on config reads, stop-grant acks and routing
module brc_top_checker
	import brc_pkg::*;
#(
	parameter int NSEC = BRC_NUM_SEC
) (
	input wire logic            clk,          // Clock
	input wire logic            resetn,       // Reset
	input wire logic            cfg_rd,       // Read
	input wire logic [7:0]      cfg_addr,     // Offset
	input wire logic [15:0]     cfg_rdata,    // Read data
	input wire logic            sg_seen,      // Stop-grant
	input wire logic            sg_ack,       // Ack
	input wire logic            acc_req,      // Access
	input wire logic            acc_is_io,    // I/O
	input wire logic [31:0]     acc_addr,     // Address
	input wire logic [2:0]      acc_io_len,   // Length
	input wire logic [NSEC-1:0] vga_en,       // VGA enables
	input wire logic            route_valid,  // Valid
	input wire logic [1:0]      route_target  // Target
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// One byte in the parallel range while no bridge claims VGA
	sequence s_par_novga;
		acc_req && acc_is_io && vga_en == '0 && acc_io_len == 3'h0 &&
			acc_addr[9:2] == BRC_PAR_LO[9:2];
	endsequence
	// Mono-only port 3BF or any alias, single byte
	sequence s_mono_only;
		acc_req && acc_is_io && acc_io_len == 3'h0 &&
			acc_addr[9:0] == BRC_MDA_P5;
	endsequence
	a_valid_follows_req: assert property (acc_req |=> route_valid)
		else $error("no decision after an access");
	a_valid_only_req: assert property (!acc_req |=> !route_valid)
		else $error("decision without an access");
	a_ack_needs_sg: assert property (!sg_seen |=> !sg_ack)
		else $error("ack without a stop-grant");
	a_rsvd_read_zero: assert property (
		cfg_rd |=> (cfg_rdata & 16'h1FDF) == 16'h0000)
		else $error("reserved bits read nonzero");
	a_unmapped_zero: assert property (
		cfg_rd && cfg_addr != BRC_CFG_OFFSET |=> cfg_rdata == 16'h0000)
		else $error("unmapped offset read nonzero");
	a_rdata_holds: assert property (!cfg_rd |=> $stable(cfg_rdata))
		else $error("read data moved without a read");
	a_par_primary: assert property (
		s_par_novga |=> route_target == BRC_TGT_PRIMARY)
		else $error("parallel range left primary link");
	a_mono_primary: assert property (
		s_mono_only |=> route_target == BRC_TGT_PRIMARY)
		else $error("mono-only port left primary link");
endmodule
bind brc_top brc_top_checker #(.NSEC(NSEC)) u_chk (.*);

// ---- brc_far_model.sv ----
`timescale 1ns/1ns
// Processors issuing stop-grants and bridges holding their levels
module brc_far_model (
	input  wire logic  clk,     // Clock
	input  wire logic  sg_ack,  // Ack
	output logic       sg_seen, // Stop-grant
	output logic [2:0] vga_en,  // VGA enables
	output logic [2:0] isa_en,  // ISA enables
	output logic [2:0] io_win,  // Window hits
	output logic [2:0] vga_hit  // VGA hits
);
	int acks = 0;
	// Tallied so extra or missing ack packets show up
	always @(posedge clk) if (sg_ack) acks++;
	// Back to back, the fastest a bus can issue them
	task automatic stop_grants(input int k);
		repeat (k) @(posedge clk) #1 sg_seen = 1'h1;
		@(posedge clk) #1 sg_seen = 1'h0;
	endtask
	task automatic bridges(input logic [2:0] v, i, w, h);
		vga_en = v;
		isa_en = i;
		io_win = w;
		vga_hit = h;
	endtask
	initial begin
		sg_seen = 1'h0;
		bridges(3'h0, 3'h0, 3'h0, 3'h0);
	end
endmodule

// ---- tb_brc_top.sv ----
`timescale 1ns/1ns
module tb_brc_top
	import brc_pkg::*;
;
	logic clk, sg_seen, sg_ack, route_valid;
	logic resetn = 1'h0, cfg_wr = 1'h0, cfg_rd = 1'h0, acc_req = 1'h0;
	logic acc_is_io = 1'h0;
	logic [7:0] cfg_addr = 8'h00;
	logic [1:0] cfg_be = 2'h0, route_target;
	logic [15:0] cfg_wdata = 16'h0000, cfg_rdata;
	logic [31:0] acc_addr = 32'h0;
	logic [2:0] acc_io_len = 3'h0, vga_en, isa_en, io_win, vga_hit;
	logic [2:0] n_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	int error_cnt = 0;
	int checked = 0;
	brc_top dut (.*);
	brc_far_model far (.*);
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [1:0] b,
		input logic [15:0] d);
		@(posedge clk) #1 cfg_wr = 1'h1;
		cfg_addr = a;
		cfg_be = b;
		cfg_wdata = d;
		@(posedge clk) #1 cfg_wr = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk) #1 cfg_rd = 1'h1;
		cfg_addr = a;
		@(posedge clk) #1 cfg_rd = 1'h0;
		chk(cfg_rdata, e);
	endtask
	// 2(n+1) stop-grants in a row must give exactly two acks
	task automatic sg_run(input logic [2:0] n);
		int a0;
		wr(8'h50, 2'h2, {n, 13'h0000});
		rd(8'h50, {n, 13'h0000});
		a0 = far.acks;
		far.stop_grants(2 * (int'(n) + 1));
		repeat (2) @(posedge clk);
		chk(16'(far.acks - a0), 16'h0002);
	endtask
	// b holds vga, isa, window, hit as one nibble each
	task automatic rt(input logic io, input logic [31:0] a,
		input logic [2:0] l, input logic m, input logic [15:0] b,
		input logic [1:0] e);
		wr(8'h50, 2'h1, {10'h000, m, 5'h00});
		far.bridges(b[14:12], b[10:8], b[6:4], b[2:0]);
		@(posedge clk) #1 acc_req = 1'h1;
		acc_is_io = io;
		acc_addr = a;
		acc_io_len = l;
		@(posedge clk) #1 acc_req = 1'h0;
		chk({13'h0000, route_valid, route_target},
			{13'h0001, e});
	endtask
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 resetn = 1'h1;
		rd(8'h50, 16'h0000);
		wr(8'h50, 2'h3, 16'hFFFF);
		rd(8'h50, 16'hE020);
		wr(8'h54, 2'h3, 16'hFFFF);
		rd(8'h54, 16'h0000);
		wr(8'h50, 2'h3, 16'h0000);
		rd(8'h50, 16'h0000);
		foreach (n_tab[k]) sg_run(n_tab[k]);
		rt(1'h1, 32'h3BC, 3'h0, 1'h0, 16'h0010, 2'h0);
		rt(1'h1, 32'h3BC, 3'h0, 1'h0, 16'h1020, 2'h2);
		rt(1'h1, 32'h3BC, 3'h0, 1'h0, 16'h1220, 2'h0);
		rt(1'h1, 32'hF7BF, 3'h0, 1'h0, 16'h1020, 2'h0);
		rt(1'h1, 32'h3B4, 3'h0, 1'h0, 16'h2000, 2'h2);
		rt(1'h1, 32'h3B4, 3'h0, 1'h1, 16'h2000, 2'h0);
		rt(1'h1, 32'h3BA, 3'h2, 1'h0, 16'h1020, 2'h1);
		rt(1'h0, 32'hB0000, 3'h0, 1'h0, 16'h4004, 2'h3);
		rt(1'h0, 32'hB7FFF, 3'h0, 1'h1, 16'h4004, 2'h0);
		rt(1'h0, 32'hB8000, 3'h0, 1'h1, 16'h4004, 2'h3);
		rt(1'h1, 32'h3C0, 3'h0, 1'h1, 16'h2002, 2'h2);
		rd(8'h50, 16'hE020);
		final_report;
	end
	// Whole run is about 140 cycles; this cuts a hang short
	initial begin
		#100000;
		error_cnt++;
		final_report;
	end
endmodule
